//--- src/cpt_pkg.sv
package cpt_pkg;
  // Register offsets
  localparam logic [7:0] OFS_DEBUG = 8'hC0;
  localparam logic [7:0] OFS_CONFIG = 8'hC2;
  localparam logic [7:0] OFS_CONTROL = 8'hC3;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'hC5;
  localparam logic [7:0] OFS_IRQ_MASK = 8'hC6;
  localparam logic [7:0] OFS_INDIRECT = 8'hC7;
  // Reset values
  localparam logic [7:0] RST_DEBUG = 8'h00;
  localparam logic [7:0] RST_CONFIG = 8'h82;
  localparam logic [7:0] RST_CONTROL = 8'h00;
  // Debug register fields
  localparam int DBG_EARLY_OFF = 4;
  localparam int DBG_CHKSUM = 3;
  localparam int DBG_FC_TEST = 2;
  localparam int DBG_TMR_FAST = 1;
  localparam int DBG_BUS_FAST = 0;
  // Config register fields
  localparam int CFG_ENHANCED_LINK_VERIFY = 7;
  localparam int CFG_ENH_SIG = 6;
  localparam int CFG_RPTR = 5;
  localparam int CFG_POL_HI = 4;
  localparam int CFG_POL_LO = 3;
  localparam int CFG_WAIT = 2;
  localparam int CFG_DET_Q = 1;
  localparam int CFG_MUTE = 0;
  // Control register field
  localparam int CTL_ENC_EN = 2;
  // Interrupt status fields
  localparam int IRQ_DETECT = 0;
  localparam int IRQ_INTEGRITY = 1;
  // Encryption policy codes
  typedef enum logic [1:0] {
    POL_AUTH = 2'h0,
    POL_REG = 2'h1,
    POL_ALWAYS = 2'h2,
    POL_INBAND = 2'h3
  } cpt_policy_t;
  // Frame cadence masks (period minus one)
  localparam logic [6:0] VERIFY_MASK_NORM = 7'h0F;
  localparam logic [6:0] VERIFY_MASK_TEST = 7'h01;
  localparam logic [6:0] INTEG_MASK_NORM = 7'h7F;
  localparam logic [6:0] INTEG_MASK_TEST = 7'h0F;
  // Start-up wait timing
  localparam int CLK_HZ = 20_000_000;
  localparam int WAIT_MS = 100;
  localparam int WAIT_CYCLES = CLK_HZ / 1000 * WAIT_MS;
  localparam int SPEEDUP_SHIFT = 10;
endpackage

//--- src/cpt_line_checksum.sv
module cpt_line_checksum
  import cpt_pkg::*;
#(
  parameter int CHANNELS = 3
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Video line
  input wire logic enable,
  input wire logic pix_valid,
  input wire logic [8*CHANNELS-1:0] pix_data,
  input wire logic line_end,
  // Checksum out
  output logic sum_valid,
  output logic [8*CHANNELS-1:0] sum_data
);
  // Running ones-complement sum per channel
  logic [8*CHANNELS-1:0] acc;

  // Marks the checksum beat after each line
  always_ff @(posedge clk) begin
    if (reset) begin
      sum_valid <= 1'b0;
    end else begin
      sum_valid <= enable && line_end;
    end
  end

  genvar ch;
  generate
    for (ch = 0; ch < CHANNELS; ch++) begin : g_chan
      // Sum with end-around carry
      logic [8:0] raw;
      assign raw = {1'b0, acc[8*ch+:8]} + {1'b0, pix_data[8*ch+:8]};
      // Accumulate, then emit complement and restart at line end
      always_ff @(posedge clk) begin
        if (reset) begin
          acc[8*ch+:8] <= 8'h00;
          sum_data[8*ch+:8] <= 8'h00;
        end else if (line_end) begin
          sum_data[8*ch+:8] <= ~acc[8*ch+:8];
          acc[8*ch+:8] <= 8'h00;
        end else if (pix_valid) begin
          acc[8*ch+:8] <= raw[7:0] + {7'h00, raw[8]};
        end
      end
    end
  endgenerate
endmodule

//--- src/cpt_config.sv
// Summary of operation
// - Check integrity value around frame 128
// - Ones-complement checksum per channel after lines
// - Test cadence: verify every 2, integrity 16
// - Normal cadence: verify every 16, integrity 128
// - Timer speed-up accelerates authentication timers
// - Fast bus timing bit, mirrored indirectly
// - Enhanced link verify gates 16th frame check
// - Signalling select: enhanced or original style
// - Repeater enable turns on repeater steps
// - Two-bit field selects encryption policy
// - Optional 100 ms start-up wait
// - Detect interrupt optionally needs receive lock
// - Stream mute ignores encryption status controls
// - Always-encrypt makes enable read one
// - Encrypt if authenticated, else blue screen (always mode, or register/inband policy when enabled)
module cpt_config
  import cpt_pkg::*;
#(
  parameter int WAIT_COUNT = WAIT_CYCLES,
  parameter int CHANNELS = 3
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [7:0] reg_rdata,
  // Interrupt
  output logic irq,
  // Link and video events
  input wire logic frame_start,
  input wire logic authenticated,
  input wire logic inband_encrypt,
  input wire logic rx_detect,
  input wire logic rx_lock,
  input wire logic wait_start,
  // Video line for checksums
  input wire logic pix_valid,
  input wire logic [8*CHANNELS-1:0] pix_data,
  input wire logic line_end,
  output logic sum_valid,
  output logic [8*CHANNELS-1:0] sum_data,
  // Cadence pulses
  output logic verify_tick,
  output logic verify_check,
  output logic integrity_tick,
  output logic early_check,
  // Mode outputs
  output logic timer_accelerate,
  output logic bus_fast_timing,
  output logic enhanced_status_signalling,
  output logic repeater_enable,
  output logic encrypt_active,
  output logic blue_screen,
  output logic mute_active,
  output logic wait_done
);
  // Software registers
  logic [7:0] protect_debug;
  logic [7:0] protect_config;
  logic enc_enable;
  logic [1:0] irq_status;
  logic [1:0] irq_mask;
  // Copies applied at frame start
  logic [7:0] act_debug;
  logic [7:0] act_config;
  logic act_enc;
  logic frame_inband;
  cpt_policy_t policy;
  // Frame counter and derived next value
  logic [6:0] frame_cnt;
  logic [6:0] next_frame;
  logic [6:0] vmask;
  logic [6:0] imask;
  // Detect qualification and edge
  logic detect_q;
  logic detect_prev;
  logic detect_rise;
  // Start-up wait counter
  logic [31:0] wait_cnt;
  logic waiting;
  logic [31:0] wait_len;
  // Events feeding the status register
  logic [1:0] irq_event;
  logic enc_read;

  assign policy = cpt_policy_t'(act_config[CFG_POL_HI:CFG_POL_LO]);
  // Enable reads one while always-encrypt is selected
  assign enc_read = enc_enable ||
    (protect_config[CFG_POL_HI:CFG_POL_LO] == POL_ALWAYS);

  // Configuration and debug registers hold until rewritten
  always_ff @(posedge clk) begin
    if (reset) begin
      protect_debug <= RST_DEBUG;
      protect_config <= RST_CONFIG;
    end else if (reg_write) begin
      if (reg_addr == OFS_DEBUG) begin
        protect_debug <= {3'h0, reg_wdata[4:0]};
      end
      if (reg_addr == OFS_CONFIG) begin
        protect_config <= reg_wdata;
      end
    end
  end

  // Encryption enable, frozen while always-encrypt is chosen
  always_ff @(posedge clk) begin
    if (reset) begin
      enc_enable <= RST_CONTROL[CTL_ENC_EN];
    end else if (reg_write && reg_addr == OFS_CONTROL &&
        protect_config[CFG_POL_HI:CFG_POL_LO] != POL_ALWAYS) begin
      enc_enable <= reg_wdata[CTL_ENC_EN];
    end
  end

  // Interrupt mask register
  always_ff @(posedge clk) begin
    if (reset) begin
      irq_mask <= 2'h0;
    end else if (reg_write && reg_addr == OFS_IRQ_MASK) begin
      irq_mask <= reg_wdata[1:0];
    end
  end

  // Sticky status, write one clears, a new event wins
  always_ff @(posedge clk) begin
    if (reset) begin
      irq_status <= 2'h0;
    end else begin
      irq_status <= (irq_status &
        ~((reg_write && reg_addr == OFS_IRQ_STATUS) ?
          reg_wdata[1:0] : 2'h0)) | irq_event;
    end
  end

  // Interrupt line from unmasked status
  always_ff @(posedge clk) begin
    if (reset) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_status & irq_mask);
    end
  end

  // Read data one cycle after the strobe
  always_ff @(posedge clk) begin
    if (reset) begin
      reg_rdata <= 8'h00;
    end else if (reg_read) begin
      case (reg_addr)
        OFS_DEBUG: reg_rdata <= protect_debug;
        OFS_CONFIG: reg_rdata <= protect_config;
        OFS_CONTROL: reg_rdata <= {5'h00, enc_read, 2'h0};
        OFS_IRQ_STATUS: reg_rdata <= {6'h00, irq_status};
        OFS_IRQ_MASK: reg_rdata <= {6'h00, irq_mask};
        OFS_INDIRECT: reg_rdata <=
          {7'h00, protect_debug[DBG_BUS_FAST]};
        default: reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // Mode settings take effect at the next frame boundary; detect qualification and start-up wait use the live registers
  always_ff @(posedge clk) begin
    if (reset) begin
      act_debug <= RST_DEBUG;
      act_config <= RST_CONFIG;
      act_enc <= 1'b0;
      frame_inband <= 1'b0;
    end else if (frame_start) begin
      act_debug <= protect_debug;
      act_config <= protect_config;
      act_enc <= enc_read;
      frame_inband <= inband_encrypt;
    end
  end

  // Cadence masks chosen by the test bit
  always_comb begin
    next_frame = frame_cnt + 7'h01;
    if (act_debug[DBG_FC_TEST]) begin
      vmask = VERIFY_MASK_TEST;
      imask = INTEG_MASK_TEST;
    end else begin
      vmask = VERIFY_MASK_NORM;
      imask = INTEG_MASK_NORM;
    end
  end

  // Frame counter
  always_ff @(posedge clk) begin
    if (reset) begin
      frame_cnt <= 7'h00;
    end else if (frame_start) begin
      frame_cnt <= next_frame;
    end
  end

  // Verification and integrity pulses on frame boundaries
  always_ff @(posedge clk) begin
    if (reset) begin
      verify_tick <= 1'b0;
      verify_check <= 1'b0;
      integrity_tick <= 1'b0;
      early_check <= 1'b0;
    end else begin
      verify_tick <= frame_start && ((next_frame & vmask) == 7'h00);
      verify_check <= frame_start && act_config[CFG_ENHANCED_LINK_VERIFY] &&
        ((next_frame & vmask) == 7'h00);
      integrity_tick <= frame_start &&
        ((next_frame & imask) == 7'h00);
      // Early check lands on the frame just before the integrity frame
      early_check <= frame_start && !act_debug[DBG_EARLY_OFF] &&
        ((next_frame & imask) == imask);
    end
  end

  // Static mode outputs
  always_ff @(posedge clk) begin
    if (reset) begin
      timer_accelerate <= 1'b0;
      bus_fast_timing <= 1'b0;
      enhanced_status_signalling <= 1'b0;
      repeater_enable <= 1'b0;
      mute_active <= 1'b0;
    end else begin
      timer_accelerate <= act_debug[DBG_TMR_FAST];
      bus_fast_timing <= act_debug[DBG_BUS_FAST];
      enhanced_status_signalling <= act_config[CFG_ENH_SIG];
      repeater_enable <= act_config[CFG_RPTR];
      mute_active <= act_config[CFG_MUTE];
    end
  end

  // Encryption decision, held still while muted
  always_ff @(posedge clk) begin
    if (reset) begin
      encrypt_active <= 1'b0;
      blue_screen <= 1'b0;
    end else if (!act_config[CFG_MUTE]) begin
      case (policy)
        POL_AUTH: begin
          encrypt_active <= authenticated;
          blue_screen <= 1'b0;
        end
        POL_REG: begin
          encrypt_active <= act_enc && authenticated;
          blue_screen <= act_enc && !authenticated;
        end
        POL_ALWAYS: begin
          encrypt_active <= authenticated;
          blue_screen <= !authenticated;
        end
        POL_INBAND: begin
          encrypt_active <= frame_inband && authenticated;
          blue_screen <= frame_inband && !authenticated;
        end
        default: begin
          encrypt_active <= 1'b0;
          blue_screen <= 1'b0;
        end
      endcase
    end
  end

  // Qualified receiver detect and its rising edge
  assign detect_q = rx_detect &&
    (!protect_config[CFG_DET_Q] || rx_lock);
  assign detect_rise = detect_q && !detect_prev;
  assign irq_event = {integrity_tick, detect_rise};

  // Remembers previous qualified detect
  always_ff @(posedge clk) begin
    if (reset) begin
      detect_prev <= 1'b0;
    end else begin
      detect_prev <= detect_q;
    end
  end

  // Wait length, shortened under timer speed-up
  assign wait_len = protect_debug[DBG_TMR_FAST] ?
    32'(WAIT_COUNT >> SPEEDUP_SHIFT) : 32'(WAIT_COUNT);

  // Start-up wait: immediate unless enabled
  always_ff @(posedge clk) begin
    if (reset) begin
      waiting <= 1'b0;
      wait_cnt <= 32'h0;
      wait_done <= 1'b0;
    end else if (wait_start) begin
      waiting <= protect_config[CFG_WAIT];
      wait_cnt <= 32'h1;
      wait_done <= !protect_config[CFG_WAIT];
    end else if (waiting) begin
      wait_cnt <= wait_cnt + 32'h1;
      // Comparing count plus one raises done on the edge where the count reaches the wait length
      wait_done <= (wait_cnt + 32'h1 >= wait_len);
      waiting <= (wait_cnt + 32'h1 < wait_len);
    end else begin
      wait_done <= 1'b0;
    end
  end

  // Per-line channel checksums
  cpt_line_checksum #(
    .CHANNELS(CHANNELS)
  ) u_checksum (
    .clk(clk),
    .reset(reset),
    .enable(act_debug[DBG_CHKSUM]),
    .pix_valid(pix_valid),
    .pix_data(pix_data),
    .line_end(line_end),
    .sum_valid(sum_valid),
    .sum_data(sum_data)
  );

  a_integ_cadence: assert property (
    @(posedge clk) disable iff (reset)
    integrity_tick |-> $past(frame_start) && frame_cnt[3:0] == 4'h0)
    else $error("integrity tick off cadence");
  a_early_place: assert property (
    @(posedge clk) disable iff (reset)
    early_check |-> $past(frame_start) && frame_cnt[3:0] == 4'hF)
    else $error("early check off its frame");
  a_early_skip: assert property (
    @(posedge clk) disable iff (reset)
    early_check |-> !$past(act_debug[DBG_EARLY_OFF]))
    else $error("early check while disabled");
  a_verify_test: assert property (
    @(posedge clk) disable iff (reset)
    verify_tick && $past(act_debug[DBG_FC_TEST]) |-> !frame_cnt[0])
    else $error("verify tick not every 2");
  a_verify_norm: assert property (
    @(posedge clk) disable iff (reset)
    verify_tick && !$past(act_debug[DBG_FC_TEST]) |->
      frame_cnt[3:0] == 4'h0)
    else $error("verify tick not every 16");
  a_lv_gate: assert property (
    @(posedge clk) disable iff (reset)
    verify_check |-> verify_tick && $past(act_config[CFG_ENHANCED_LINK_VERIFY]))
    else $error("verify check without enhanced");
  a_always_read: assert property (
    @(posedge clk) disable iff (reset)
    reg_read && reg_addr == OFS_CONTROL &&
      protect_config[4:3] == 2'h2 |=> reg_rdata[CTL_ENC_EN])
    else $error("enable not one in always mode");
  a_blue_auth: assert property (
    @(posedge clk) disable iff (reset)
    blue_screen |-> !encrypt_active)
    else $error("blue screen while encrypting");
  a_mute_hold: assert property (
    @(posedge clk) disable iff (reset)
    $past(act_config[CFG_MUTE]) |-> $stable(encrypt_active))
    else $error("encryption moved during mute");
  a_wait_skip: assert property (
    @(posedge clk) disable iff (reset)
    wait_start && !protect_config[CFG_WAIT] |=> wait_done)
    else $error("wait applied when disabled");
  a_detect_lock: assert property (
    @(posedge clk) disable iff (reset)
    detect_rise && protect_config[CFG_DET_Q] |-> rx_lock ##1
      irq_status[IRQ_DETECT])
    else $error("detect irq without lock");
endmodule

//--- bench/cpt_rx_model.sv
module cpt_rx_model (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Requested receiver state
  input wire logic want_det,
  input wire logic want_lock,
  input wire logic want_auth,
  input wire logic want_inb,
  input wire logic want_wait,
  // Receiver indications
  output logic rx_detect,
  output logic rx_lock,
  output logic authenticated,
  output logic inband_encrypt,
  output logic wait_start
);
  timeunit 1ns;
  timeprecision 1ns;
  // Indications follow requests one edge later
  always_ff @(posedge clk) begin
    if (reset) begin
      rx_detect <= 1'b0;
      rx_lock <= 1'b0;
      authenticated <= 1'b0;
      inband_encrypt <= 1'b0;
      wait_start <= 1'b0;
    end else begin
      rx_detect <= want_det;
      // A receiver that is absent cannot report lock
      rx_lock <= want_det & want_lock;
      authenticated <= want_auth;
      inband_encrypt <= want_inb;
      wait_start <= want_wait;
    end
  end
endmodule

//--- bench/tb_top.sv
module tb_top
  import cpt_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  // Clock, reset and register port
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic [7:0] reg_rdata;
  // Video side
  logic frame_start = 1'b0;
  logic pix_valid = 1'b0;
  logic line_end = 1'b0;
  logic [23:0] pix_data = 24'h000000;
  logic [23:0] sum_data;
  // Receiver model requests
  logic want_det = 1'b0;
  logic want_lock = 1'b0;
  logic want_auth = 1'b0;
  logic want_inb = 1'b0;
  logic want_wait = 1'b0;
  // Design outputs and receiver levels
  logic irq, rx_detect, rx_lock, authenticated, inband_encrypt, wait_start;
  logic sum_valid, verify_tick, verify_check, integrity_tick, early_check;
  logic timer_accelerate, bus_fast_timing, enhanced_status_signalling;
  logic repeater_enable, encrypt_active, blue_screen, mute_active, wait_done;
  // Counters
  int err_count = 0;
  int n_compared = 0;
  int nv, nc, ni, ne;
  logic cnt_on = 1'b0;

  // Short start-up wait so both wait lengths fit in the run
  localparam int WAIT_SIM = 4096;
  localparam int WAIT_FAST = WAIT_SIM >> SPEEDUP_SHIFT;

  cpt_config #(
    .WAIT_COUNT(WAIT_SIM),
    .CHANNELS(3)
  ) i_cpt_config (
    .clk(clk),
    .reset(reset),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_write(reg_write),
    .reg_read(reg_read),
    .reg_rdata(reg_rdata),
    .irq(irq),
    .frame_start(frame_start),
    .authenticated(authenticated),
    .inband_encrypt(inband_encrypt),
    .rx_detect(rx_detect),
    .rx_lock(rx_lock),
    .wait_start(wait_start),
    .pix_valid(pix_valid),
    .pix_data(pix_data),
    .line_end(line_end),
    .sum_valid(sum_valid),
    .sum_data(sum_data),
    .verify_tick(verify_tick),
    .verify_check(verify_check),
    .integrity_tick(integrity_tick),
    .early_check(early_check),
    .timer_accelerate(timer_accelerate),
    .bus_fast_timing(bus_fast_timing),
    .enhanced_status_signalling(enhanced_status_signalling),
    .repeater_enable(repeater_enable),
    .encrypt_active(encrypt_active),
    .blue_screen(blue_screen),
    .mute_active(mute_active),
    .wait_done(wait_done)
  );
  cpt_rx_model i_cpt_rx_model (
    .clk(clk),
    .reset(reset),
    .want_det(want_det),
    .want_lock(want_lock),
    .want_auth(want_auth),
    .want_inb(want_inb),
    .want_wait(want_wait),
    .rx_detect(rx_detect),
    .rx_lock(rx_lock),
    .authenticated(authenticated),
    .inband_encrypt(inband_encrypt),
    .wait_start(wait_start)
  );

  // Clock of 50 ns period
  always #25 clk = ~clk;

  // Tick counting window
  always @(posedge clk) begin
    if (cnt_on) begin
      nv += verify_tick;
      nc += verify_check;
      ni += integrity_tick;
      ne += early_check;
    end
  end

  task automatic conclude();
    $display("compared %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [23:0] g, input logic [23:0] e, string m);
    n_compared++;
    if (g !== e) begin
      err_count++;
      $display("unexpected at %0t: %s", $time, m);
    end
  endtask

  // One-cycle write strobe
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clk);
    reg_write <= 1'b0;
  endtask

  // Read, data stands in the following cycle
  task automatic rc(input logic [7:0] a, e, k, input string m);
    @(posedge clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clk);
    reg_read <= 1'b0;
    #1 chk(24'(reg_rdata & k), 24'(e), m);
  endtask

  // Frames four cycles apart
  task automatic frames(input int n);
    repeat (n) begin
      @(posedge clk);
      frame_start <= 1'b1;
      @(posedge clk);
      frame_start <= 1'b0;
      repeat (2) @(posedge clk);
    end
  endtask

  // Expected {encrypt, blue} per policy
  function automatic logic [1:0] enc_exp(logic [1:0] p, logic en, a);
    case (p)
      2'h0: return {a, 1'b0};
      2'h2: return {a, ~a};
      default: return {en & a, en & ~a};
    endcase
  endfunction

  // Ones-complement add with end-around carry
  function automatic logic [7:0] ocs(logic [7:0] s, logic [7:0] b);
    logic [8:0] t;
    t = 9'(s) + 9'(b);
    return t[7:0] + 8'(t[8]);
  endfunction

  // Count ticks over n frames, expectation from the set bits
  task automatic cad(input logic [7:0] dbg, input logic [7:0] cfg, int n);
    int v, i;
    v = n / (dbg[2] ? 2 : 16);
    i = n / (dbg[2] ? 16 : 128);
    wr(OFS_DEBUG, dbg);
    wr(OFS_CONFIG, cfg);
    frames(2);
    nv = 0;
    nc = 0;
    ni = 0;
    ne = 0;
    #1 cnt_on = 1'b1;
    frames(n);
    #1 cnt_on = 1'b0;
    chk(24'(nv), 24'(v), "verify count");
    chk(24'(nc), cfg[7] ? 24'(v) : 24'h0, "verify check count");
    chk(24'(ni), 24'(i), "integrity count");
    chk(24'(ne), dbg[4] ? 24'h0 : 24'(i), "early check count");
  endtask

  // Policy case; inband level follows the enable
  task automatic pol(input logic [1:0] p, input logic en, a);
    logic [1:0] ea;
    logic [7:0] ec;
    // Enable reads one whenever always-encrypt is chosen
    ea = enc_exp(p, en, a);
    ec = {5'h00, en | (p == 2'h2), 2'h0};
    want_auth <= a;
    want_inb <= en;
    wr(OFS_CONFIG, {3'h4, p, 3'h2});
    wr(OFS_CONTROL, {5'h00, en, 2'h0});
    frames(1);
    #1 chk(24'({encrypt_active, blue_screen}), 24'(ea), "enc");
    rc(OFS_CONTROL, ec, 8'hFF, "ctl");
  endtask

  // Start-up wait length in cycles
  task automatic meas(output int n);
    @(posedge clk);
    want_wait <= 1'b1;
    @(posedge clk);
    want_wait <= 1'b0;
    n = 0;
    do begin
      @(posedge clk);
      #1 n++;
    end while (wait_done !== 1'b1 && n < 2 * WAIT_SIM);
  endtask

  initial begin
    logic [7:0] r;
    logic [23:0] px, acc;
    int n;
    void'($urandom(32'h5cf0));
    repeat (10) @(posedge clk);
    reset <= 1'b0;
    // Reset values and an unmapped place
    rc(OFS_DEBUG, RST_DEBUG, 8'hFF, "debug reset");
    rc(OFS_CONFIG, RST_CONFIG, 8'hFF, "config reset");
    rc(OFS_CONTROL, RST_CONTROL, 8'hFF, "control reset");
    rc(8'h10, 8'h00, 8'hFF, "unmapped");
    // Random debug bits
    r = 8'($urandom);
    wr(OFS_DEBUG, r);
    rc(OFS_DEBUG, r & 8'h1F, 8'hFF, "debug readback");
    frames(1);
    #1 chk(24'(timer_accelerate), 24'(r[1]), "timer");
    chk(24'(bus_fast_timing), 24'(r[0]), "bus timing");
    rc(OFS_INDIRECT, {7'h00, r[0]}, 8'h01, "mirror");
    // Random config, mute off
    r = 8'($urandom) & 8'hFE;
    wr(OFS_CONFIG, r);
    rc(OFS_CONFIG, r, 8'hFF, "config readback");
    frames(1);
    #1 chk(24'(enhanced_status_signalling), 24'(r[6]), "sig");
    chk(24'(repeater_enable), 24'(r[5]), "repeater");
    // Detect interrupt qualification, mask and clear
    wr(OFS_CONFIG, 8'h82);
    wr(OFS_IRQ_MASK, 8'h01);
    wr(OFS_IRQ_STATUS, 8'h03);
    want_det <= 1'b1;
    repeat (4) @(posedge clk);
    #1 chk(24'(irq), 24'h0, "detect without lock");
    want_lock <= 1'b1;
    repeat (4) @(posedge clk);
    #1 chk(24'(irq), 24'h1, "detect with lock");
    rc(OFS_IRQ_STATUS, 8'h01, 8'h01, "detect status");
    wr(OFS_IRQ_STATUS, 8'h01);
    want_lock <= 1'b0;
    repeat (3) @(posedge clk);
    #1 chk(24'(irq), 24'h0, "cleared");
    wr(OFS_CONFIG, 8'h80);
    repeat (3) @(posedge clk);
    #1 chk(24'(irq), 24'h1, "plain detect");
    wr(OFS_IRQ_MASK, 8'h00);
    repeat (3) @(posedge clk);
    #1 chk(24'(irq), 24'h0, "masked");
    wr(OFS_IRQ_STATUS, 8'h03);
    want_det <= 1'b0;
    // Frame cadences
    cad(8'h00, 8'h82, 128);
    cad(8'h04, 8'h82, 32);
    cad(8'h14, 8'h02, 32);
    rc(OFS_IRQ_STATUS, 8'h02, 8'h02, "integrity status");
    // Every policy with enable and authentication
    for (int k = 0; k < 16; k++) begin
      pol(2'(k >> 2), k[1], k[0]);
    end
    // Mute holds outputs while authentication drops
    pol(2'h1, 1'b1, 1'b1);
    wr(OFS_CONFIG, 8'hC9);
    frames(1);
    want_auth <= 1'b0;
    frames(2);
    #1 chk(24'({mute_active, encrypt_active}), 24'h3, "mute");
    chk(24'(blue_screen), 24'h0, "mute blue");
    wr(OFS_CONFIG, 8'hC8);
    frames(1);
    #1 chk(24'({mute_active, encrypt_active}), 24'h0, "unmute");
    chk(24'(blue_screen), 24'h1, "unmute blue");
    // Line checksum, first pixel all ones
    wr(OFS_DEBUG, 8'h08);
    frames(1);
    acc = 24'h000000;
    for (int k = 0; k < 5; k++) begin
      px = (k == 0) ? 24'hFFFFFF : 24'($urandom);
      @(posedge clk);
      pix_valid <= 1'b1;
      pix_data <= px;
      acc = {ocs(acc[23:16], px[23:16]), ocs(acc[15:8], px[15:8]),
             ocs(acc[7:0], px[7:0])};
    end
    @(posedge clk);
    pix_valid <= 1'b0;
    line_end <= 1'b1;
    @(posedge clk);
    line_end <= 1'b0;
    #1 chk(24'(sum_valid), 24'h1, "sum valid");
    chk(sum_data, ~acc, "sum data");
    // Start-up wait off, then on
    wr(OFS_CONFIG, 8'h82);
    meas(n);
    chk(24'(n <= 2), 24'h1, "no wait");
    wr(OFS_CONFIG, 8'h86);
    meas(n);
    chk(24'(n >= WAIT_SIM - 1), 24'h1, "wait too short");
    chk(24'(n <= WAIT_SIM + 3), 24'h1, "wait too long");
    // Speed-up shortens the same wait
    wr(OFS_DEBUG, 8'h02);
    meas(n);
    chk(24'(n >= WAIT_FAST - 1), 24'h1, "fast wait short");
    chk(24'(n <= WAIT_FAST + 3), 24'h1, "fast wait long");
    conclude();
  end

  // Watchdog
  initial begin
    repeat (30000) @(posedge clk);
    err_count++;
    conclude();
  end
endmodule
